// [tcw_pkg.sv]
package tcw_pkg;
	// register byte offsets
	localparam logic [7:0] TCW_OFS_CTRL = 8'h00;
	localparam logic [7:0] TCW_OFS_COUNT = 8'h04;
	localparam logic [7:0] TCW_OFS_COMPARE = 8'h08;
	localparam logic [7:0] TCW_OFS_FLAGS = 8'h0C;
	localparam logic [7:0] TCW_OFS_IRQ_EN = 8'h10;
	localparam logic [7:0] TCW_OFS_PORT = 8'h14;
	// control field positions
	localparam int TCW_CTRL_MODE_LSB = 0;
	localparam int TCW_CTRL_ACTION_LSB = 2;
	localparam int TCW_CTRL_CLKSRC_LSB = 4;
	localparam int TCW_CTRL_FORCE_BIT = 7;
	// flag and enable positions
	localparam int TCW_FLAG_COMPARE_BIT = 0;
	localparam int TCW_FLAG_OVERFLOW_BIT = 1;
	// port register positions
	localparam int TCW_PORT_DATA_BIT = 0;
	localparam int TCW_PORT_DIR_BIT = 1;
	// waveform modes
	localparam logic [1:0] TCW_MODE_NORMAL = 2'h0;
	localparam logic [1:0] TCW_MODE_PHASE_PWM = 2'h1;
	localparam logic [1:0] TCW_MODE_CLEAR_ON_MATCH = 2'h2;
	localparam logic [1:0] TCW_MODE_FAST_PWM = 2'h3;
	// output actions and the clock source stop code
	localparam logic [1:0] TCW_ACT_NONE = 2'h0;
	localparam logic [1:0] TCW_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TCW_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TCW_ACT_SET = 2'h3;
	localparam logic [2:0] TCW_CLKSRC_STOP = 3'h0;
	// count limits
	localparam logic [7:0] TCW_BOTTOM = 8'h00;
	localparam logic [7:0] TCW_MAX = 8'hFF;
	// reset values
	localparam logic [7:0] TCW_RST_COUNT = 8'h00;
	localparam logic [7:0] TCW_RST_COMPARE = 8'h00;
	localparam logic [1:0] TCW_RST_MODE = 2'h0;
	localparam logic [1:0] TCW_RST_ACTION = 2'h0;
	localparam logic [2:0] TCW_RST_CLKSRC = 3'h0;
endpackage

// [tcw_timer8.sv]
`timescale 1ns/1ns
module tcw_timer8
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer clock enable from the prescaler
	input wire logic timer_tick,
	// interrupt requests and service acknowledges
	output logic compare_irq,
	output logic overflow_irq,
	input wire logic compare_irq_ack,
	input wire logic overflow_irq_ack,
	// wave pin
	output logic wave_pin_out,
	output logic wave_pin_oe
);
	import tcw_pkg::*;

	logic [1:0] waveform_mode_sel_r, output_action_sel_r;
	logic [2:0] clock_source_sel_r;
	logic [7:0] count_value_r, count_nxt, compare_value_r, compare_buf_r;
	logic count_down_r, count_down_nxt, compare_flag_r, overflow_flag_r, match_pend_r;
	logic compare_irq_enable_r, overflow_irq_enable_r, port_data_r, wave_pin_direction_r;
	logic wave_output_r, wave_nxt, block_r, pready_r, pslverr_r, addr_ok;
	logic [31:0] prdata_r, rd_data;
	logic compare_irq_r, overflow_irq_r, wave_pin_out_r, wave_pin_oe_r;
	logic acc, wr_en, wr_ctrl, wr_count, wr_compare, wr_flags, wr_force, tick_en;
	logic pwm_mode, match, ovf_evt, buf_load, fast_bottom;

	// apb: one wait state, so the write edge is the one that samples pready
	assign acc = psel & penable & ~pready_r;
	assign wr_en = psel & penable & pready_r & pwrite;
	assign wr_ctrl = wr_en & (paddr == TCW_OFS_CTRL);
	assign wr_count = wr_en & (paddr == TCW_OFS_COUNT);
	assign wr_compare = wr_en & (paddr == TCW_OFS_COMPARE);
	assign wr_flags = wr_en & (paddr == TCW_OFS_FLAGS);
	assign wr_force = wr_ctrl & pwdata[TCW_CTRL_FORCE_BIT];

	assign tick_en = timer_tick & (clock_source_sel_r != TCW_CLKSRC_STOP);
	assign pwm_mode = (waveform_mode_sel_r == TCW_MODE_PHASE_PWM) |
		(waveform_mode_sel_r == TCW_MODE_FAST_PWM);
	assign match = tick_en & (count_value_r == compare_value_r) & ~block_r;
	assign fast_bottom = tick_en & (waveform_mode_sel_r == TCW_MODE_FAST_PWM) &
		(count_value_r == TCW_MAX);
	// fast pwm reloads at bottom, phase correct at top; both occur with count at max
	assign buf_load = tick_en & pwm_mode & (count_value_r == TCW_MAX);
	assign ovf_evt = tick_en & ((waveform_mode_sel_r == TCW_MODE_PHASE_PWM) ?
		(count_down_r & (count_value_r == 8'h01)) : (count_value_r == TCW_MAX));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end
		else
		begin
			pready_r <= acc;
			pslverr_r <= acc & ~addr_ok;
			if (acc)
				prdata_r <= rd_data;
		end
	end

	always_comb
	begin
		addr_ok = 1'b1;
		rd_data = 32'h0;
		case (paddr)
			TCW_OFS_CTRL:
			begin
				rd_data[TCW_CTRL_MODE_LSB +: 2] = waveform_mode_sel_r;
				rd_data[TCW_CTRL_ACTION_LSB +: 2] = output_action_sel_r;
				rd_data[TCW_CTRL_CLKSRC_LSB +: 3] = clock_source_sel_r;
			end
			TCW_OFS_COUNT: rd_data[7:0] = count_value_r;
			TCW_OFS_COMPARE: rd_data[7:0] = pwm_mode ? compare_buf_r : compare_value_r;
			TCW_OFS_FLAGS:
			begin
				rd_data[TCW_FLAG_COMPARE_BIT] = compare_flag_r;
				rd_data[TCW_FLAG_OVERFLOW_BIT] = overflow_flag_r;
			end
			TCW_OFS_IRQ_EN:
			begin
				rd_data[TCW_FLAG_COMPARE_BIT] = compare_irq_enable_r;
				rd_data[TCW_FLAG_OVERFLOW_BIT] = overflow_irq_enable_r;
			end
			TCW_OFS_PORT:
			begin
				rd_data[TCW_PORT_DATA_BIT] = port_data_r;
				rd_data[TCW_PORT_DIR_BIT] = wave_pin_direction_r;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// control, enable and port registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			waveform_mode_sel_r <= TCW_RST_MODE;
			output_action_sel_r <= TCW_RST_ACTION;
			clock_source_sel_r <= TCW_RST_CLKSRC;
			compare_irq_enable_r <= 1'b0;
			overflow_irq_enable_r <= 1'b0;
			port_data_r <= 1'b0;
			wave_pin_direction_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				waveform_mode_sel_r <= pwdata[TCW_CTRL_MODE_LSB +: 2];
				output_action_sel_r <= pwdata[TCW_CTRL_ACTION_LSB +: 2];
				clock_source_sel_r <= pwdata[TCW_CTRL_CLKSRC_LSB +: 3];
			end
			if (wr_en & (paddr == TCW_OFS_IRQ_EN))
			begin
				compare_irq_enable_r <= pwdata[TCW_FLAG_COMPARE_BIT];
				overflow_irq_enable_r <= pwdata[TCW_FLAG_OVERFLOW_BIT];
			end
			if (wr_en & (paddr == TCW_OFS_PORT))
			begin
				port_data_r <= pwdata[TCW_PORT_DATA_BIT];
				wave_pin_direction_r <= pwdata[TCW_PORT_DIR_BIT];
			end
		end
	end

	// counting sequence, chosen by mode only
	always_comb
	begin
		count_nxt = count_value_r;
		count_down_nxt = count_down_r;
		if (tick_en)
		begin
			case (waveform_mode_sel_r)
				TCW_MODE_NORMAL: count_nxt = count_value_r + 8'h01;
				TCW_MODE_FAST_PWM: count_nxt = count_value_r + 8'h01;
				// a compare value below the count is only met after the wrap
				TCW_MODE_CLEAR_ON_MATCH: count_nxt = match ? TCW_BOTTOM :
					count_value_r + 8'h01;
				TCW_MODE_PHASE_PWM:
				begin
					// turn at max going up and at bottom going down
					if (count_value_r == (count_down_r ? TCW_BOTTOM : TCW_MAX))
						count_down_nxt = ~count_down_r;
					count_nxt = count_down_nxt ? count_value_r - 8'h01 : count_value_r + 8'h01;
				end
				default: count_nxt = count_value_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_value_r <= TCW_RST_COUNT;
			count_down_r <= 1'b0;
		end
		else
		begin
			count_value_r <= wr_count ? pwdata[7:0] : count_nxt;
			count_down_r <= count_down_nxt & (waveform_mode_sel_r == TCW_MODE_PHASE_PWM);
		end
	end

	// block lasts until the next tick has gone by, even with the clock stopped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			block_r <= 1'b0;
		else if (wr_count)
			block_r <= 1'b1;
		else if (tick_en)
			block_r <= 1'b0;
	end

	// compare value and its buffer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			compare_value_r <= TCW_RST_COMPARE;
			compare_buf_r <= TCW_RST_COMPARE;
		end
		else
		begin
			if (wr_compare)
				compare_buf_r <= pwdata[7:0];
			if (wr_compare & ~pwm_mode)
				compare_value_r <= pwdata[7:0];
			else if (buf_load)
				compare_value_r <= compare_buf_r;
		end
	end

	// flags: hardware set beats software clear and interrupt service
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			match_pend_r <= 1'b0;
			compare_flag_r <= 1'b0;
			overflow_flag_r <= 1'b0;
		end
		else
		begin
			if (tick_en)
				match_pend_r <= match;
			if (tick_en & match_pend_r)
				compare_flag_r <= 1'b1;
			else if ((wr_flags & pwdata[TCW_FLAG_COMPARE_BIT]) | compare_irq_ack)
				compare_flag_r <= 1'b0;
			if (ovf_evt)
				overflow_flag_r <= 1'b1;
			else if ((wr_flags & pwdata[TCW_FLAG_OVERFLOW_BIT]) | overflow_irq_ack)
				overflow_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			compare_irq_r <= 1'b0;
			overflow_irq_r <= 1'b0;
		end
		else
		begin
			compare_irq_r <= compare_flag_r & compare_irq_enable_r & ~compare_irq_ack;
			overflow_irq_r <= overflow_flag_r & overflow_irq_enable_r & ~overflow_irq_ack;
		end
	end

	// waveform generator; action is read live, so a new setting acts at once
	always_comb
	begin
		wave_nxt = wave_output_r;
		if (wr_force & ~pwm_mode)
		begin
			case (pwdata[TCW_CTRL_ACTION_LSB +: 2])
				TCW_ACT_TOGGLE: wave_nxt = ~wave_output_r;
				TCW_ACT_CLEAR: wave_nxt = 1'b0;
				TCW_ACT_SET: wave_nxt = 1'b1;
				default: wave_nxt = wave_output_r;
			endcase
		end
		else if (fast_bottom & output_action_sel_r[1])
			wave_nxt = ~output_action_sel_r[0]; // at bottom wins so max gives steady level
		else if (match)
		begin
			case (output_action_sel_r)
				TCW_ACT_TOGGLE: wave_nxt = ~wave_output_r;
				TCW_ACT_CLEAR: wave_nxt = (waveform_mode_sel_r == TCW_MODE_PHASE_PWM) ?
					count_down_r : 1'b0;
				TCW_ACT_SET: wave_nxt = (waveform_mode_sel_r == TCW_MODE_PHASE_PWM) ?
					~count_down_r : 1'b1;
				default: wave_nxt = wave_output_r;
			endcase
		end
	end

	// no reset on mode change: the output only moves through wave_nxt
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wave_output_r <= 1'b0;
		else
			wave_output_r <= wave_nxt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wave_pin_out_r <= 1'b0;
			wave_pin_oe_r <= 1'b0;
		end
		else
		begin
			wave_pin_out_r <= (output_action_sel_r != TCW_ACT_NONE) ? wave_output_r :
				port_data_r;
			wave_pin_oe_r <= wave_pin_direction_r;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign compare_irq = compare_irq_r;
	assign overflow_irq = overflow_irq_r;
	assign wave_pin_out = wave_pin_out_r;
	assign wave_pin_oe = wave_pin_oe_r;

	property p_match_equal;
		@(posedge pclk) disable iff (!presetn)
		(tick_en && (count_value_r == compare_value_r) && !block_r) |=> match_pend_r;
	endproperty
	a_match_equal: assert property (p_match_equal) else $error("equal count gave no match");
	property p_flag_delay;
		@(posedge pclk) disable iff (!presetn)
		(tick_en && match_pend_r) |=> compare_flag_r;
	endproperty
	a_flag_delay: assert property (p_flag_delay) else $error("flag not set after match");
	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(compare_flag_r && compare_irq_enable_r && !compare_irq_ack) |=> compare_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("enabled flag raised no request");
	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		(wr_flags && pwdata[TCW_FLAG_COMPARE_BIT] && !(tick_en && match_pend_r))
		|=> !compare_flag_r;
	endproperty
	a_w1c: assert property (p_w1c) else $error("compare flag not cleared");
	property p_buffered;
		@(posedge pclk) disable iff (!presetn)
		(pwm_mode && !buf_load && !(wr_ctrl)) |=> $stable(compare_value_r);
	endproperty
	a_buffered: assert property (p_buffered) else $error("active compare moved off update");
	property p_force;
		@(posedge pclk) disable iff (!presetn)
		(wr_force && !pwm_mode && !tick_en && !wr_count && !wr_flags && !compare_irq_ack)
		|=> $stable(count_value_r) && $stable(compare_flag_r);
	endproperty
	a_force: assert property (p_force) else $error("force touched count or flag");
	property p_block;
		@(posedge pclk) disable iff (!presetn)
		$past(wr_count) && !wr_count |-> !match;
	endproperty
	a_block: assert property (p_block) else $error("match after count write");
	property p_stop;
		@(posedge pclk) disable iff (!presetn)
		(clock_source_sel_r == TCW_CLKSRC_STOP && !wr_count) |=> $stable(count_value_r);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped counter moved");
	property p_ctc_clear;
		@(posedge pclk) disable iff (!presetn)
		(waveform_mode_sel_r == TCW_MODE_CLEAR_ON_MATCH && match && !wr_count)
		|=> count_value_r == TCW_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("no clear after match");
	property p_pin_dir;
		@(posedge pclk) disable iff (!presetn)
		!wave_pin_direction_r |=> !wave_pin_oe;
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("pin driven as input");
	property p_action_zero;
		@(posedge pclk) disable iff (!presetn)
		(output_action_sel_r == TCW_ACT_NONE && !wr_force) |=> $stable(wave_output_r);
	endproperty
	a_action_zero: assert property (p_action_zero) else $error("output moved with no action");
endmodule

// [tcw_timer8_tb.sv]
`timescale 1ns/1ns
module tb;
	import tcw_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, timer_tick;
	logic compare_irq_ack, overflow_irq_ack, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, q;
	logic [31:0] prdata;
	logic pready, pslverr, compare_irq, overflow_irq, wave_pin_out, wave_pin_oe;
	logic [1:0] acts [4];
	logic exps [4];
	int failures, checks_done;

	tcw_timer8 u_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
		.compare_irq(compare_irq), .overflow_irq(overflow_irq),
		.compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
		.wave_pin_out(wave_pin_out), .wave_pin_oe(wave_pin_oe)
	);

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task chk_bit(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask

	// master holds the request until pready is sampled high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16)
		begin
			failures++;
			$display("wrong value pready expected 1 seen 0");
			print_verdict();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk_reg(n, e, q);
	endtask

	// tick held high for n sampling edges gives n timer clocks
	task ticks(input int n);
		@(posedge pclk);
		timer_tick <= 1'b1;
		repeat (n) @(posedge pclk);
		timer_tick <= 1'b0;
	endtask

	task waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] a,
		input logic [2:0] c, input logic f);
		return {24'h0, f, c, a, m};
	endfunction

	initial
	begin
		{presetn, psel, penable, pwrite, timer_tick} = 5'h0;
		{compare_irq_ack, overflow_irq_ack} = 2'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		checks_done = 0;
		acts = '{TCW_ACT_TOGGLE, TCW_ACT_SET, TCW_ACT_CLEAR, TCW_ACT_NONE};
		exps = '{1'b1, 1'b1, 1'b0, 1'b1};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(TCW_OFS_CTRL, 32'h0, "ctrl");
		rd(TCW_OFS_COUNT, 32'h0, "count");
		rd(TCW_OFS_COMPARE, 32'h0, "compare");
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		rd(8'h18, 32'h0, "unmapped");
		chk_bit("slverr", 1'b1, err);
		// normal mode wrap and overflow
		wr(TCW_OFS_COMPARE, 32'h80);
		wr(TCW_OFS_COUNT, 32'hFE);
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_NONE, 3'h1, 1'b0));
		ticks(1);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		ticks(1);
		rd(TCW_OFS_COUNT, 32'h0, "count");
		rd(TCW_OFS_FLAGS, 32'h2, "flags");
		wr(TCW_OFS_IRQ_EN, 32'h2);
		waitc(2);
		chk_bit("overflow irq", 1'b1, overflow_irq);
		@(posedge pclk);
		overflow_irq_ack <= 1'b1;
		@(posedge pclk);
		overflow_irq_ack <= 1'b0;
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		chk_bit("overflow irq", 1'b0, overflow_irq);
		// flag lags the match by one timer clock
		wr(TCW_OFS_COMPARE, 32'h10);
		wr(TCW_OFS_COUNT, 32'h0E);
		ticks(3);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		ticks(1);
		rd(TCW_OFS_FLAGS, 32'h1, "flags");
		wr(TCW_OFS_FLAGS, 32'h0);
		rd(TCW_OFS_FLAGS, 32'h1, "flags");
		wr(TCW_OFS_FLAGS, 32'h1);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		// stopped clock holds count; a count write blocks the next match
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_NONE, TCW_CLKSRC_STOP, 1'b0));
		ticks(3);
		rd(TCW_OFS_COUNT, 32'h12, "count");
		wr(TCW_OFS_COUNT, 32'h10);
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_NONE, 3'h1, 1'b0));
		ticks(3);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		rd(TCW_OFS_COUNT, 32'h13, "count");
		// port data on the pin while no action is selected
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_CLEAR, 3'h1, 1'b1));
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_NONE, 3'h1, 1'b0));
		wr(TCW_OFS_PORT, 32'h3);
		waitc(2);
		chk_bit("pin", 1'b1, wave_pin_out);
		chk_bit("oe", 1'b1, wave_pin_oe);
		// clear-on-match toggling with interrupt
		wr(TCW_OFS_COMPARE, 32'h3);
		wr(TCW_OFS_COUNT, 32'h0);
		wr(TCW_OFS_IRQ_EN, 32'h1);
		wr(TCW_OFS_CTRL, cw(TCW_MODE_CLEAR_ON_MATCH, TCW_ACT_TOGGLE, 3'h1, 1'b0));
		waitc(2);
		chk_bit("pin", 1'b0, wave_pin_out);
		ticks(4);
		waitc(2);
		chk_bit("pin", 1'b1, wave_pin_out);
		rd(TCW_OFS_COUNT, 32'h0, "count");
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		chk_bit("irq", 1'b0, compare_irq);
		ticks(1);
		rd(TCW_OFS_FLAGS, 32'h1, "flags");
		chk_bit("irq", 1'b1, compare_irq);
		@(posedge pclk);
		compare_irq_ack <= 1'b1;
		@(posedge pclk);
		compare_irq_ack <= 1'b0;
		waitc(2);
		chk_bit("irq", 1'b0, compare_irq);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		ticks(3);
		waitc(2);
		chk_bit("pin", 1'b0, wave_pin_out);
		// each action, changed between matches, applies at the next match
		for (int i = 0; i < 4; i++)
		begin
			wr(TCW_OFS_CTRL, cw(TCW_MODE_CLEAR_ON_MATCH, acts[i], 3'h1, 1'b0));
			wr(TCW_OFS_COUNT, 32'h0);
			ticks(4);
			waitc(2);
			chk_bit("pin", exps[i], wave_pin_out);
		end
		wr(TCW_OFS_CTRL, cw(TCW_MODE_CLEAR_ON_MATCH, TCW_ACT_TOGGLE, 3'h1, 1'b0));
		waitc(2);
		chk_bit("pin", 1'b0, wave_pin_out);
		// mode change keeps the output; force strobe
		wr(TCW_OFS_CTRL, cw(TCW_MODE_FAST_PWM, TCW_ACT_SET, 3'h1, 1'b0));
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_SET, 3'h1, 1'b0));
		waitc(2);
		chk_bit("pin", 1'b0, wave_pin_out);
		wr(TCW_OFS_FLAGS, 32'h1);
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_SET, 3'h1, 1'b1));
		waitc(2);
		chk_bit("pin", 1'b1, wave_pin_out);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		rd(TCW_OFS_COUNT, 32'h0, "count");
		rd(TCW_OFS_CTRL, 32'h1C, "ctrl");
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_TOGGLE, 3'h1, 1'b1));
		waitc(2);
		chk_bit("pin", 1'b0, wave_pin_out);
		// fast pwm mode writes the buffer; active compare stays until bottom
		wr(TCW_OFS_CTRL, cw(TCW_MODE_FAST_PWM, TCW_ACT_NONE, 3'h1, 1'b0));
		wr(TCW_OFS_COMPARE, 32'h40);
		rd(TCW_OFS_COMPARE, 32'h40, "compare");
		wr(TCW_OFS_COUNT, 32'h1);
		// first tick lands the match left pending by the last clear-on-match run
		ticks(1);
		wr(TCW_OFS_FLAGS, 32'h1);
		ticks(3);
		rd(TCW_OFS_FLAGS, 32'h1, "flags");
		wr(TCW_OFS_FLAGS, 32'h1);
		wr(TCW_OFS_CTRL, cw(TCW_MODE_NORMAL, TCW_ACT_NONE, 3'h1, 1'b0));
		rd(TCW_OFS_COMPARE, 32'h3, "compare");
		wr(TCW_OFS_COMPARE, 32'h20);
		rd(TCW_OFS_COMPARE, 32'h20, "compare");
		// compare written below the count waits for the wrap
		wr(TCW_OFS_CTRL, cw(TCW_MODE_CLEAR_ON_MATCH, TCW_ACT_NONE, 3'h1, 1'b0));
		wr(TCW_OFS_COUNT, 32'h05);
		wr(TCW_OFS_COMPARE, 32'h02);
		ticks(250);
		rd(TCW_OFS_FLAGS, 32'h0, "flags");
		ticks(1);
		rd(TCW_OFS_FLAGS, 32'h2, "flags");
		ticks(2);
		rd(TCW_OFS_COUNT, 32'h2, "count");
		ticks(1);
		rd(TCW_OFS_COUNT, 32'h0, "count");
		wr(8'h18, 32'h1);
		chk_bit("slverr", 1'b1, err);
		print_verdict();
	end
endmodule
